// file: common/rpf_pkg.sv
// rpf_pkg: constants and types for the power-fail gate and square-wave selector
// assumes a 20 MHz system clock and an 8-bit register map on a 32-bit wishbone
package rpf_pkg;
   // clock and recovery interval
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned REC_TIME_US   = 150000;
   localparam int unsigned REC_CYCLES    = (REC_TIME_US * 1000) / CLK_PERIOD_NS;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL_A  = 8'h00;
   localparam logic [7:0] OFS_CTRL_B  = 8'h04;
   localparam logic [7:0] OFS_EXT     = 8'h08;
   localparam logic [7:0] OFS_STATUS  = 8'h0C;
   localparam logic [7:0] OFS_SECONDS = 8'h10;
   // field positions
   localparam int unsigned RS_LSB     = 0;
   localparam int unsigned DV_LSB     = 4;
   localparam int unsigned SQ_WAVE_EN_BIT = 3;
   localparam int unsigned FORCE_32K_BIT  = 0;
   localparam int unsigned AUX_BAT_EN_BIT = 1;
   localparam int unsigned OSCEN_BIT  = 2;
   localparam int unsigned ST_RUN_BIT = 0;
   localparam int unsigned ST_AUX_BIT = 1;
   // divider chain
   localparam int unsigned CHAIN_W  = 15;
   localparam logic [3:0]  TAP_MIN  = 4'h1;
   localparam logic [3:0]  TAP_MAX  = 4'hD;
   localparam logic [1:0]  DV_RESET = 2'h3;
   // reset values
   localparam logic [3:0]  RS_RST   = 4'h0;
   localparam logic [2:0]  DV_RST   = 3'h2;

   typedef struct packed {
      logic [2:0] dv;
      logic [3:0] rs;
      logic       square_wave_enable;
      logic       force_32k_output_enable;
      logic       aux_battery_enable;
      logic       osc_en;
   } rpf_ctrl_type;

   typedef enum logic [1:0] {
      ST_FAIL,
      ST_RECOVER,
      ST_ACCESS
   } rpf_state_type;
endpackage : rpf_pkg

// file: rtl/rpf_core.sv
// rpf_core: power-fail access gate, recovery timer, divider chain and square-wave pin
// assumes oscillator, comparator, aux and kickstart pins are asynchronous to clk_i
// Function
// RULE1: after power-up and recovery interval, 32kHz square wave drives the pin.
// RULE2: power-up sets divider control bit one and the forced 32kHz enable.
// RULE3: pin toggles when square-wave enable or forced 32kHz enable is set.
// RULE4: forced 32kHz wins; otherwise the rate-select bits choose the tap.
// RULE5: thirteen selectable taps on a fifteen-stage oscillator divider chain.
// RULE6: in power fail, 32kHz still out if forced, aux enabled, aux present.
// RULE7: in power fail, host accesses are blocked as if chip select inactive.
// RULE8: in power fail, inputs ignored, outputs released except kickstart, power, wave.
// RULE9: after power returns, access only after recovery, oscillator and chain running.
// RULE10: oscillator disabled at power-up: enable it and grant access immediately.
// RULE11: timekeeping keeps counting while host access is blocked.
// RULE12: software clears aux battery enable when no aux battery is fitted.
// RULE13: comparator power-fail level is synchronised before it gates anything.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
module rpf_core #(
   parameter int unsigned REC_CYCLES = rpf_pkg::REC_CYCLES
) (
   // system
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // pins
   input  wire logic        osc_clk_i,
   input  wire logic        power_fail_i,
   input  wire logic        aux_battery_supply_i,
   input  wire logic        kickstart_in_n_i,
   output logic             square_wave_out_o,
   output logic             bus_oe_o,
   output logic             power_on_out_n_o
);

   // synchronisers
   logic pf_s1_q, pf_s2_q;
   logic osc_s1_q, osc_s2_q, osc_s3_q;
   logic aux_s1_q, aux_s2_q;
   logic kick_s1_q, kick_s2_q, kick_s3_q;

   rpf_pkg::rpf_ctrl_type  ctrl_q;
   rpf_pkg::rpf_state_type st_q;
   logic [31:0]            rec_cnt_q;
   logic                   rec_done;
   logic [rpf_pkg::CHAIN_W-1:0] chain_q;
   logic                   chain_run;
   logic                   osc_rise;
   logic                   sec_tick;
   logic [31:0]            sec_q;
   logic                   wb_req;
   logic                   wr_en;
   logic                   power_up;
   logic                   kick_req_q;
   logic                   wave_d;
   logic [31:0]            rd_d;

   // tap select for a given rate code
   function automatic logic tap_sel(input logic [3:0] rs,
                                    input logic [rpf_pkg::CHAIN_W-1:0] ch);
      logic r;
      r = 1'b0;
      if (rs >= rpf_pkg::TAP_MIN && rs <= rpf_pkg::TAP_MAX) begin
         r = ch[rs];
      end
      return r;
   endfunction : tap_sel

   // two-flop synchronisers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pf_s1_q <= 1'b1;
         pf_s2_q <= 1'b1;
      end else begin
         pf_s1_q <= power_fail_i;
         pf_s2_q <= pf_s1_q; // RULE13
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
         aux_s1_q <= 1'b0;
         aux_s2_q <= 1'b0;
         kick_s1_q <= 1'b1;
         kick_s2_q <= 1'b1;
         kick_s3_q <= 1'b1;
      end else begin
         osc_s1_q <= osc_clk_i;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
         aux_s1_q <= aux_battery_supply_i;
         aux_s2_q <= aux_s1_q;
         kick_s1_q <= kickstart_in_n_i;
         kick_s2_q <= kick_s1_q;
         kick_s3_q <= kick_s2_q;
      end
   end

   assign osc_rise  = osc_s2_q & ~osc_s3_q;
   assign chain_run = ctrl_q.osc_en & (ctrl_q.dv[2:1] != rpf_pkg::DV_RESET);
   assign sec_tick  = osc_rise & chain_run & (&chain_q);
   assign rec_done  = (rec_cnt_q >= REC_CYCLES - 1);
   assign power_up  = (st_q == rpf_pkg::ST_FAIL) & ~pf_s2_q;

   // divider chain, 15 stages on the oscillator
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chain_q <= '0;
      end else if (!chain_run) begin
         chain_q <= '0;
      end else if (osc_rise) begin
         chain_q <= chain_q + 15'h0001; // RULE5
      end
   end

   // seconds count, independent of access gating
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sec_q <= 32'h0000_0000;
      end else if (sec_tick) begin
         sec_q <= sec_q + 32'h0000_0001; // RULE11
      end
   end

   // access state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= rpf_pkg::ST_FAIL;
      end else if (pf_s2_q) begin
         st_q <= rpf_pkg::ST_FAIL; // RULE13
      end else begin
         case (st_q)
            rpf_pkg::ST_FAIL: begin
               if (!ctrl_q.osc_en) begin
                  st_q <= rpf_pkg::ST_ACCESS; // RULE10
               end else begin
                  st_q <= rpf_pkg::ST_RECOVER;
               end
            end
            rpf_pkg::ST_RECOVER: begin
               if (rec_done && chain_run) begin
                  st_q <= rpf_pkg::ST_ACCESS; // RULE9
               end
            end
            default: begin
               st_q <= rpf_pkg::ST_ACCESS;
            end
         endcase
      end
   end

   // recovery interval counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rec_cnt_q <= 32'h0000_0000;
      end else if (st_q != rpf_pkg::ST_RECOVER) begin
         rec_cnt_q <= 32'h0000_0000;
      end else if (!rec_done) begin
         rec_cnt_q <= rec_cnt_q + 32'h0000_0001; // RULE9
      end
   end

   // wishbone request, blocked outside access
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en  = wb_req & wb_we_i & wb_sel_i[0] & (st_q == rpf_pkg::ST_ACCESS); // RULE7

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_req;
      end
   end

   // control registers; power-up set wins over a write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q.rs     <= rpf_pkg::RS_RST;
         ctrl_q.dv     <= rpf_pkg::DV_RST;
         ctrl_q.square_wave_enable      <= 1'b0;
         ctrl_q.force_32k_output_enable <= 1'b0;
         ctrl_q.aux_battery_enable      <= 1'b0;
         ctrl_q.osc_en                  <= 1'b1;
      end else begin
         if (wr_en) begin
            if (wb_adr_i == rpf_pkg::OFS_CTRL_A) begin
               ctrl_q.rs <= wb_dat_i[rpf_pkg::RS_LSB +: 4];
               ctrl_q.dv <= wb_dat_i[rpf_pkg::DV_LSB +: 3];
            end else if (wb_adr_i == rpf_pkg::OFS_CTRL_B) begin
               ctrl_q.square_wave_enable <= wb_dat_i[rpf_pkg::SQ_WAVE_EN_BIT];
            end else if (wb_adr_i == rpf_pkg::OFS_EXT) begin
               ctrl_q.force_32k_output_enable <= wb_dat_i[rpf_pkg::FORCE_32K_BIT];
               ctrl_q.aux_battery_enable      <= wb_dat_i[rpf_pkg::AUX_BAT_EN_BIT]; // RULE12
               ctrl_q.osc_en                  <= wb_dat_i[rpf_pkg::OSCEN_BIT];
            end
         end
         if (power_up) begin
            ctrl_q.dv[1]                   <= 1'b1; // RULE2
            ctrl_q.force_32k_output_enable <= 1'b1; // RULE2
            ctrl_q.osc_en                  <= 1'b1; // RULE10
         end
      end
   end

   // read mux
   always_comb begin
      rd_d = 32'h0000_0000;
      if (st_q == rpf_pkg::ST_ACCESS) begin
         if (wb_adr_i == rpf_pkg::OFS_CTRL_A) begin
            rd_d[rpf_pkg::RS_LSB +: 4] = ctrl_q.rs;
            rd_d[rpf_pkg::DV_LSB +: 3] = ctrl_q.dv;
         end else if (wb_adr_i == rpf_pkg::OFS_CTRL_B) begin
            rd_d[rpf_pkg::SQ_WAVE_EN_BIT] = ctrl_q.square_wave_enable;
         end else if (wb_adr_i == rpf_pkg::OFS_EXT) begin
            rd_d[rpf_pkg::FORCE_32K_BIT]  = ctrl_q.force_32k_output_enable;
            rd_d[rpf_pkg::AUX_BAT_EN_BIT] = ctrl_q.aux_battery_enable;
            rd_d[rpf_pkg::OSCEN_BIT] = ctrl_q.osc_en;
         end else if (wb_adr_i == rpf_pkg::OFS_STATUS) begin
            rd_d[rpf_pkg::ST_RUN_BIT] = chain_run;
            rd_d[rpf_pkg::ST_AUX_BIT] = aux_s2_q;
         end else if (wb_adr_i == rpf_pkg::OFS_SECONDS) begin
            rd_d = sec_q;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_req && !wb_we_i) begin
         wb_dat_o <= rd_d; // RULE7
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // square wave source select
   always_comb begin
      wave_d = 1'b0;
      case (st_q)
         rpf_pkg::ST_ACCESS: begin
            if (ctrl_q.force_32k_output_enable) begin
               wave_d = osc_s2_q; // RULE1 RULE4
            end else if (ctrl_q.square_wave_enable) begin
               wave_d = tap_sel(ctrl_q.rs, chain_q); // RULE3 RULE4 RULE5
            end
         end
         rpf_pkg::ST_FAIL: begin
            if (ctrl_q.force_32k_output_enable && ctrl_q.aux_battery_enable
                && aux_s2_q) begin
               wave_d = osc_s2_q; // RULE6
            end
         end
         default: begin
            wave_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         square_wave_out_o <= 1'b0;
      end else begin
         square_wave_out_o <= wave_d;
      end
   end

   // pin enables and kickstart power request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_oe_o <= 1'b0;
      end else begin
         bus_oe_o <= (st_q == rpf_pkg::ST_ACCESS) & ~pf_s2_q; // RULE8
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         kick_req_q <= 1'b0;
      end else if (st_q != rpf_pkg::ST_FAIL) begin
         kick_req_q <= 1'b0;
      end else if (!kick_s2_q && kick_s3_q && ctrl_q.aux_battery_enable && aux_s2_q) begin
         kick_req_q <= 1'b1; // RULE8
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_on_out_n_o <= 1'b1;
      end else begin
         power_on_out_n_o <= ~((st_q != rpf_pkg::ST_FAIL) | kick_req_q);
      end
   end

   // assertions
   fail_rd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
      (st_q == rpf_pkg::ST_FAIL && wb_req) |=> (wb_dat_o == 32'h0000_0000))
      else $error("read data leaked during power fail");

   fail_sync_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE13
      $rose(pf_s2_q) |=> (st_q == rpf_pkg::ST_FAIL))
      else $error("synchronised power fail did not block access");

   powerup_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
      power_up |=> (ctrl_q.dv[1] && ctrl_q.force_32k_output_enable))
      else $error("power-up did not set divider bit and 32k enable");

   wave_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
      ($past(st_q) == rpf_pkg::ST_ACCESS && !$past(ctrl_q.square_wave_enable)
       && !$past(ctrl_q.force_32k_output_enable))
      |-> !square_wave_out_o)
      else $error("square wave on while both enables clear");

   force_32k_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
      (st_q == rpf_pkg::ST_ACCESS && ctrl_q.force_32k_output_enable)
      |=> (square_wave_out_o == $past(osc_s2_q)))
      else $error("forced 32k not on the pin");

   rec_wait_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
      (st_q == rpf_pkg::ST_ACCESS && $past(st_q) == rpf_pkg::ST_RECOVER)
      |-> ($past(rec_done) && $past(chain_run)))
      else $error("access granted before recovery interval");

   osc_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
      (power_up && !ctrl_q.osc_en && !pf_s2_q) |=> (st_q == rpf_pkg::ST_ACCESS && ctrl_q.osc_en))
      else $error("disabled oscillator did not give immediate access");

   aux_32k_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
      (st_q == rpf_pkg::ST_FAIL && ctrl_q.force_32k_output_enable
       && ctrl_q.aux_battery_enable && aux_s2_q)
      |=> (square_wave_out_o == $past(osc_s2_q)))
      else $error("32k missing on aux battery during power fail");

   sec_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
      sec_tick |=> (sec_q == $past(sec_q) + 32'h0000_0001))
      else $error("seconds did not advance");

   fail_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
      (st_q == rpf_pkg::ST_FAIL) |=> !bus_oe_o)
      else $error("bus drive enabled during power fail");

   chain_step_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
      (osc_rise && chain_run) |=> (chain_q == $past(chain_q) + 15'h0001))
      else $error("divider chain did not step");

   fail_chain_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
      (st_q == rpf_pkg::ST_FAIL && osc_rise && chain_run)
      |=> (chain_q == $past(chain_q) + 15'h0001))
      else $error("divider chain stalled during power fail");

   rec_first_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
      (st_q == rpf_pkg::ST_RECOVER) |=> !square_wave_out_o)
      else $error("square wave before recovery interval ended");

endmodule : rpf_core

// file: bench/rpf_osc_model.sv
// rpf_osc_model: free-running oscillator standing in for the crystal
// assumes its default period, left as is by the bench, is scaled down to keep the run short
`timescale 1ns/100ps
module rpf_osc_model #(
   parameter int unsigned HALF_NS = 150,
   parameter int unsigned START_NS = 20
) (
   // pin
   output logic osc_o
);
   initial begin
      osc_o = 1'b0;
      #(START_NS);
      forever #(HALF_NS) osc_o = ~osc_o;
   end
endmodule : rpf_osc_model

// file: bench/rpf_core_bench.sv
// rpf_core_bench: checks power-fail gating and square-wave selection
// assumes osc half period of 3 clocks and a short recovery count
`timescale 1ns/100ps
module rpf_core_bench;
   localparam int unsigned REC = 20;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        osc_clk;
   logic        power_fail_i = 1'b1;
   logic        aux_i = 1'b1;
   logic        sq_o;
   logic        bus_oe_o;
   logic        power_on_n;
   logic        kick_n = 1'b1;
   logic [31:0] expq[$];
   int          n_errors = 0;
   int          checks_done = 0;
   int          seed = 83;
   int          n;
   int          k;

   rpf_osc_model i_rpf_osc_model (.osc_o(osc_clk));
   rpf_core #(.REC_CYCLES(REC)) i_rpf_core (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_clk_i(osc_clk),
      .power_fail_i(power_fail_i), .aux_battery_supply_i(aux_i),
      .kickstart_in_n_i(kick_n), .square_wave_out_o(sq_o), .bus_oe_o(bus_oe_o),
      .power_on_out_n_o(power_on_n));

   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   // classic single cycle, held until ack sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      wb(1'b0, a, 32'h0);
   endtask : rd

   // half period of the pin in clocks, 400 when it stands still
   task automatic sqper(output int cnt);
      logic prev;
      cnt = 0;
      repeat (8) @(posedge clk_i);
      prev = sq_o;
      while (sq_o === prev && cnt < 400) begin
         @(posedge clk_i);
         cnt++;
      end
      prev = sq_o;
      cnt = 0;
      while (sq_o === prev && cnt < 400) begin
         @(posedge clk_i);
         cnt++;
      end
   endtask : sqper

   task automatic powerup(output int cnt);
      @(posedge clk_i);
      power_fail_i <= 1'b0;
      cnt = 0;
      while (bus_oe_o !== 1'b1 && cnt < 200) begin
         @(posedge clk_i);
         cnt++;
      end
   endtask : powerup

   task automatic fail;
      @(posedge clk_i);
      power_fail_i <= 1'b1;
      repeat (10) @(posedge clk_i);
   endtask : fail

   // read checker
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         if (expq.size() == 0) chk(32'hFFFFFFFF, 32'h0);
         else chk(wb_dat_o, expq.pop_front());
      end
   end

   initial begin
      #(50 * 30000);
      n_errors++;
      results();
   end

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(rpf_pkg::OFS_EXT, 32'h0);
      chk(bus_oe_o, 1'b0);
      chk(power_on_n, 1'b1);
      $display("test fail_at_start done");
      powerup(n);
      chk(n >= REC, 1'b1);
      chk(bus_oe_o, 1'b1);
      chk(power_on_n, 1'b0);
      rd(rpf_pkg::OFS_EXT, 32'h05);
      rd(rpf_pkg::OFS_CTRL_A, 32'h20);
      sqper(n);
      chk(n, 3);
      $display("test power_up done");
      k = 1 + ($unsigned($random(seed)) % 3);
      wb(1'b1, rpf_pkg::OFS_CTRL_B, 32'h08);
      wb(1'b1, rpf_pkg::OFS_CTRL_A, 32'(k));
      sqper(n);
      chk(n, 3);
      wb(1'b1, rpf_pkg::OFS_EXT, 32'h04);
      for (int r = 1; r <= 3; r++) begin
         wb(1'b1, rpf_pkg::OFS_CTRL_A, 32'(r));
         sqper(n);
         chk(n, 32'(6 << r));
      end
      wb(1'b1, rpf_pkg::OFS_CTRL_A, 32'h00);
      sqper(n);
      chk(n, 400);
      wb(1'b1, rpf_pkg::OFS_CTRL_A, 32'(k));
      wb(1'b1, rpf_pkg::OFS_CTRL_B, 32'h00);
      sqper(n);
      chk(n, 400);
      $display("test rate_select done");
      wb(1'b1, rpf_pkg::OFS_EXT, 32'h07);
      fail();
      chk(bus_oe_o, 1'b0);
      chk(power_on_n, 1'b1);
      wb(1'b1, rpf_pkg::OFS_EXT, 32'h00);
      rd(rpf_pkg::OFS_CTRL_A, 32'h0);
      sqper(n);
      chk(n, 3);
      @(posedge clk_i);
      kick_n <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk(power_on_n, 1'b0);
      kick_n <= 1'b1;
      aux_i <= 1'b0;
      sqper(n);
      chk(n, 400);
      powerup(n);
      chk(n >= REC, 1'b1);
      rd(rpf_pkg::OFS_EXT, 32'h07);
      rd(rpf_pkg::OFS_CTRL_A, 32'h20 | 32'(k));
      rd(rpf_pkg::OFS_STATUS, 32'h01);
      $display("test fail_with_aux done");
      wb(1'b1, rpf_pkg::OFS_EXT, 32'h00);
      fail();
      chk(power_on_n, 1'b1);
      powerup(n);
      chk(n < REC, 1'b1);
      chk(bus_oe_o, 1'b1);
      rd(rpf_pkg::OFS_EXT, 32'h05);
      $display("test osc_off_power_up done");
      results();
   end
endmodule : rpf_core_bench
